// ==== verilog/eec_consts.svh ====
`ifndef EEC_CONSTS_SVH
`define EEC_CONSTS_SVH

// register indices, byte address is four times the index
`define EEC_IDX_ACR 16'hfe1f
`define EEC_IDX_CTRL 16'hfe1d
`define EEC_IDX_NVOPT 16'hfe1c
`define EEC_IDX_DIVH 16'hfe1a
`define EEC_IDX_DIVL 16'hfe1b
`define EEC_IDX_NVDIVH 16'hfe10
`define EEC_IDX_NVDIVL 16'hfe11

// array window and secured zone
`define EEC_ARR_LO 16'h0800
`define EEC_ARR_HI 16'h09ff
`define EEC_SEC_LO 16'h08f0
`define EEC_SEC_HI 16'h08ff

// control register fields
`define EEC_CTRL_SPARE 7
`define EEC_CTRL_PD 5
`define EEC_CTRL_OPHI 4
`define EEC_CTRL_OPLO 3
`define EEC_CTRL_LAT 2
`define EEC_CTRL_AUTO 1
`define EEC_CTRL_HV 0

// option and divider fields
`define EEC_ACR_SEC 4
`define EEC_DIVH_LOCK 7

// reset values
`define EEC_CTRL_RST 8'h00
`define EEC_NV_FACTORY 8'hf0
`define EEC_DIV_RST 11'h000

// timebase
`define EEC_TICK_US 35

`endif

// ==== verilog/eec_pkg.sv ====
package eec_pkg;

   typedef enum logic [1:0] {
      EEC_BYTE_PGM = 2'b00,
      EEC_BYTE_ERASE = 2'b01,
      EEC_BLOCK_ERASE = 2'b10,
      EEC_BULK_ERASE = 2'b11
   } eec_op_t;

   // gray along idle, wait, done, send
   typedef enum logic [1:0] {
      EEC_IDLE = 2'b00,
      EEC_RWAIT = 2'b01,
      EEC_RDONE = 2'b11,
      EEC_RSEND = 2'b10
   } eec_bus_t;

endpackage

// ==== verilog/eec_program_erase_ctl.sv ====
// Contract
// - power-down bit disables the array; reset clears it.
// - mode bits select program or erase kind; protected block blocks all.
// - latch-control routes bus writes into address/data capture; reset clears.
// - latch-control cannot be cleared while program enable is set.
// - with auto set, timer ends the cycle and clears program enable.
// - pump on only with latch set and a valid captured write.
// - clearing latch and enable together clears only the enable.
// - configuration register is read-only, loaded from option byte at reset.
// - security bit 0 enables security; once enabled never disabled.
// - four guard bits each protect one 128-byte quarter, in index order.
// - secured allows byte program/erase only; 08f0 to 08ff locked.
// - option byte programs like an array byte; copied after reset.
// - option byte ships as f0, erased bits read one.
// - 11-bit divisor sets the 35 us tick; reloaded after reset.
// - divider lock bit 0 locks both divider registers and their copies.
// - divisor always readable, writable only with latch clear and unlocked.
// - control bit 7 is plain storage with no effect.
// - only valid writes captured; later one replaces; reads capture address.
// - enable cannot be set without latch and a valid captured address.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "eec_consts.svh"

module eec_program_erase_ctl #(
   parameter logic [15:0] PGM_TICKS = 16'h011e,
   parameter logic [15:0] BYTE_ERASE_TICKS = 16'h011e,
   parameter logic [15:0] BLOCK_ERASE_TICKS = 16'h011e,
   parameter logic [15:0] BULK_ERASE_TICKS = 16'h011e
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [7:0] nv_option,
   input wire logic [7:0] nv_div_hi,
   input wire logic [7:0] nv_div_lo,
   input wire logic [7:0] arr_rdata,
   output logic arr_rd_en,
   output logic [15:0] arr_rd_addr,
   output logic [15:0] arr_prog_addr,
   output logic [7:0] arr_prog_data,
   output logic [1:0] arr_op,
   output logic arr_pump_on,
   output logic arr_power_down
);

   eec_pkg::eec_bus_t st;
   eec_pkg::eec_bus_t next_st;
   logic load_q;
   logic wr_pend;
   logic [15:0] addr_q;
   logic spare;
   logic pd;
   logic [1:0] op;
   logic lat;
   logic autoc;
   logic hv;
   logic lat_valid;
   logic [15:0] lat_addr;
   logic [7:0] lat_data;
   logic [7:0] acr;
   logic lock_dis;
   logic [10:0] div;
   logic [10:0] pre_cnt;
   logic [15:0] tcount;

   // bus decode
   wire accept = ce & hsel & htrans[1] & hready & ~load_q;
   wire a_map = (haddr[31:18] == 14'h0000) & (haddr[1:0] == 2'b00);
   wire [15:0] a_idx = a_map ? haddr[17:2] : 16'h0000;
   wire hit_ctrl = addr_q == `EEC_IDX_CTRL;
   wire hit_acr = addr_q == `EEC_IDX_ACR;
   wire hit_divh = addr_q == `EEC_IDX_DIVH;
   wire hit_divl = addr_q == `EEC_IDX_DIVL;
   wire hit_arr = (addr_q >= `EEC_ARR_LO) & (addr_q <= `EEC_ARR_HI);
   wire hit_nv = (addr_q == `EEC_IDX_NVOPT) | (addr_q == `EEC_IDX_NVDIVH)
      | (addr_q == `EEC_IDX_NVDIVL);
   wire hit_mem = hit_arr | hit_nv;
   wire wr_go = wr_pend & ce;
   wire [7:0] wd = hwdata[7:0];
   wire ctrl_we = wr_go & hit_ctrl;
   wire div_open = ~lat & lock_dis;
   wire divh_we = wr_go & hit_divh & div_open;
   wire divl_we = wr_go & hit_divl & div_open;

   // capture into the program latch, frozen while voltage is applied
   wire mem_we = wr_go & hit_mem & lat & ~hv;
   wire mem_rd_lat = ce & (st == eec_pkg::EEC_RDONE) & hit_mem & lat
      & ~hv;
   wire lat_cap = mem_we | mem_rd_lat;

   // permission of the captured target
   wire secured = ~acr[`EEC_ACR_SEC];
   wire [3:0] guard = acr[3:0];
   wire [1:0] blk = lat_addr[8:7];
   wire lat_in_arr = (lat_addr >= `EEC_ARR_LO) & (lat_addr <= `EEC_ARR_HI);
   wire lat_in_sec = (lat_addr >= `EEC_SEC_LO) & (lat_addr <= `EEC_SEC_HI);
   wire lat_nvopt = lat_addr == `EEC_IDX_NVOPT;
   wire lat_nvdiv = (lat_addr == `EEC_IDX_NVDIVH)
      | (lat_addr == `EEC_IDX_NVDIVL);
   wire op_pgm = op == eec_pkg::EEC_BYTE_PGM;
   wire op_byte = op_pgm | (op == eec_pkg::EEC_BYTE_ERASE);
   wire op_block = op == eec_pkg::EEC_BLOCK_ERASE;
   wire op_bulk = op == eec_pkg::EEC_BULK_ERASE;
   wire arr_ok = ~guard[blk] & ~(secured & lat_in_sec)
      & (op_byte | (~secured & (op_block
      | (op_bulk & (guard == 4'h0)))));
   // erasing the option byte would undo security, so while secured it only programs
   wire nvopt_ok = secured ? op_pgm : op_byte;
   wire nvdiv_ok = lock_dis & op_byte;
   wire op_ok = (lat_in_arr & arr_ok) | (lat_nvopt & nvopt_ok)
      | (lat_nvdiv & nvdiv_ok);
   wire pump = hv & lat & lat_valid & op_ok & ~pd;

   // timebase and termination timer
   wire [11:0] pre_next = {1'b0, pre_cnt} + 12'h001;
   wire tick = pump & (pre_next >= {1'b0, div});
   logic [15:0] dur;
   always_comb begin
      case (op)
         eec_pkg::EEC_BYTE_PGM: dur = PGM_TICKS;
         eec_pkg::EEC_BYTE_ERASE: dur = BYTE_ERASE_TICKS;
         eec_pkg::EEC_BLOCK_ERASE: dur = BLOCK_ERASE_TICKS;
         eec_pkg::EEC_BULK_ERASE: dur = BULK_ERASE_TICKS;
         default: dur = PGM_TICKS;
      endcase
   end
   wire done = pump & (tcount >= dur);
   wire auto_done = done & autoc;

   // control next values
   wire next_lat = ctrl_we ? (wd[`EEC_CTRL_LAT] | hv) : lat;
   wire next_hv = auto_done ? 1'b0
      : ctrl_we ? (wd[`EEC_CTRL_HV] & lat & lat_valid) : hv;

   // read data selection
   wire [7:0] ctrl_rd = {spare, 1'b0, pd, op, lat, autoc, hv};
   wire [7:0] rd_val = hit_ctrl ? ctrl_rd
      : hit_acr ? acr
      : hit_divh ? {lock_dis, 4'h0, div[10:8]}
      : hit_divl ? div[7:0]
      : hit_mem ? (lat ? lat_data : arr_rdata)
      : 8'h00;

   always_comb begin
      case (st)
         eec_pkg::EEC_IDLE: next_st = eec_pkg::EEC_IDLE;
         eec_pkg::EEC_RWAIT: next_st = eec_pkg::EEC_RDONE;
         eec_pkg::EEC_RDONE: next_st = eec_pkg::EEC_RSEND;
         eec_pkg::EEC_RSEND: next_st = eec_pkg::EEC_IDLE;
         default: next_st = eec_pkg::EEC_IDLE;
      endcase
      if (accept && !hwrite) begin
         next_st = eec_pkg::EEC_RWAIT;
      end
   end

   // two wait states on every read give the array a registered cycle
   assign hreadyout = ce & ~load_q & ((st == eec_pkg::EEC_IDLE)
      | (st == eec_pkg::EEC_RSEND));
   assign hresp = 1'b0;
   assign arr_rd_en = ce & (st == eec_pkg::EEC_RWAIT) & hit_mem & ~lat;
   assign arr_rd_addr = addr_q;
   assign arr_prog_addr = lat_addr;
   assign arr_prog_data = lat_data;
   assign arr_op = op;
   assign arr_pump_on = pump;
   assign arr_power_down = pd;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= eec_pkg::EEC_IDLE;
         wr_pend <= 1'b0;
         addr_q <= 16'h0000;
         hrdata <= 32'h00000000;
      end else if (ce) begin
         st <= next_st;
         if (hready) begin
            wr_pend <= accept & hwrite;
         end
         if (accept) begin
            addr_q <= a_idx;
         end
         if (st == eec_pkg::EEC_RDONE) begin
            hrdata <= {24'h000000, rd_val};
         end
      end
   end

   // option and divider load straight after reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_q <= 1'b1;
         acr <= `EEC_NV_FACTORY;
         lock_dis <= 1'b0;
         div <= `EEC_DIV_RST;
      end else if (ce) begin
         load_q <= 1'b0;
         if (load_q) begin
            acr <= nv_option;
            lock_dis <= nv_div_hi[`EEC_DIVH_LOCK];
            div <= {nv_div_hi[2:0], nv_div_lo};
         end else begin
            if (divh_we) begin
               lock_dis <= wd[`EEC_DIVH_LOCK];
               div[10:8] <= wd[2:0];
            end
            if (divl_we) begin
               div[7:0] <= wd;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {spare, pd, op, autoc} <= 5'h00;
         lat <= 1'b0;
         hv <= 1'b0;
      end else if (ce) begin
         if (ctrl_we) begin
            spare <= wd[`EEC_CTRL_SPARE];
            pd <= wd[`EEC_CTRL_PD];
            op <= wd[`EEC_CTRL_OPHI:`EEC_CTRL_OPLO];
            autoc <= wd[`EEC_CTRL_AUTO];
         end
         lat <= next_lat;
         hv <= next_hv;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lat_valid <= 1'b0;
         lat_addr <= 16'h0000;
         lat_data <= 8'hff;
      end else if (ce) begin
         if (!next_lat) begin
            lat_valid <= 1'b0;
         end else if (mem_we) begin
            lat_valid <= 1'b1;
         end
         if (lat_cap) begin
            lat_addr <= addr_q;
         end
         if (mem_we) begin
            lat_data <= wd;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_cnt <= 11'h000;
         tcount <= 16'h0000;
      end else if (ce) begin
         if (!pump || tick) begin
            pre_cnt <= 11'h000;
         end else begin
            pre_cnt <= pre_next[10:0];
         end
         if (!pump) begin
            tcount <= 16'h0000;
         end else if (tick && !done) begin
            tcount <= tcount + 16'h0001;
         end
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_pd_gates_pump: assert property (
      arr_power_down |-> !arr_pump_on)
      else $error("pump on while powered down");

   chk_guard_blocks: assert property (
      arr_pump_on && lat_in_arr |-> !guard[blk])
      else $error("pump on in guarded quarter");

   chk_secure_modes: assert property (
      arr_pump_on && lat_in_arr && secured |-> op_byte && !lat_in_sec)
      else $error("secured array allowed wrong operation");

   chk_latch_held: assert property (
      ce && hv |=> lat)
      else $error("latch cleared while enable set");

   chk_both_clear: assert property (
      ce && ctrl_we && hv && !wd[`EEC_CTRL_LAT] && !wd[`EEC_CTRL_HV]
      |=> lat && !hv)
      else $error("double clear did not keep latch");

   chk_auto_clear: assert property (
      ce && hv && autoc && done |=> !hv)
      else $error("auto termination did not clear enable");

   chk_noauto_keep: assert property (
      ce && hv && !autoc && !ctrl_we |=> hv)
      else $error("enable cleared without auto");

   chk_hv_needs_lat: assert property (
      $rose(hv) |-> $past(lat) && $past(lat_valid))
      else $error("enable set without valid latch");

   chk_acr_readonly: assert property (
      !load_q |=> $stable(acr))
      else $error("configuration changed after load");

   chk_div_locked: assert property (
      ce && !load_q && (lat || !lock_dis)
      |=> $stable(div) && $stable(lock_dis))
      else $error("divisor changed while locked");

   chk_read_waits: assert property (
      ce && st == eec_pkg::EEC_RWAIT ##1 ce |-> st == eec_pkg::EEC_RDONE
      ##1 (st == eec_pkg::EEC_RSEND || !ce))
      else $error("read sequence broken");

   chk_pump_needs_lat: assert property (
      arr_pump_on |-> lat && lat_valid && !arr_power_down)
      else $error("pump on without valid latch");

   // an erased option byte would drop security again
   chk_nvopt_secured: assert property (
      arr_pump_on && lat_nvopt && secured |-> op_pgm)
      else $error("secured option byte erased");

   chk_nvdiv_locked: assert property (
      arr_pump_on && lat_nvdiv |-> lock_dis)
      else $error("locked divisor copy altered");

endmodule

// ==== test/eec_array_model.sv ====
`timescale 1ns/1ps
`include "eec_consts.svh"

module eec_array_model (
   input wire logic hclk,
   input wire logic arr_rd_en,
   input wire logic [15:0] arr_rd_addr,
   input wire logic [15:0] arr_prog_addr,
   input wire logic [7:0] arr_prog_data,
   input wire logic [1:0] arr_op,
   input wire logic arr_pump_on,
   input wire logic arr_power_down,
   output logic [7:0] arr_rdata,
   output logic [7:0] nv_option,
   output logic [7:0] nv_div_hi,
   output logic [7:0] nv_div_lo
);
   logic [7:0] mem [0:511];
   logic [7:0] nvo = 8'hf0;
   logic pump_q = 1'b0;
   logic [8:0] a;
   // lock disabled, divisor 2 keeps the tick short
   assign nv_div_hi = 8'h80;
   assign nv_div_lo = 8'h02;
   assign nv_option = nvo;
   assign a = arr_prog_addr[8:0];
   initial begin
      arr_rdata = 8'h00;
      foreach (mem[i]) mem[i] = 8'hff;
   end
   always @(posedge hclk) begin
      pump_q <= arr_pump_on;
      // released or powered down: toggling garbage, never a stale value
      if (arr_rd_en && !arr_power_down && arr_rd_addr == `EEC_IDX_NVOPT)
         arr_rdata <= nvo;
      else if (arr_rd_en && !arr_power_down)
         arr_rdata <= mem[arr_rd_addr[8:0]];
      else
         arr_rdata <= ~arr_rdata;
      if (arr_pump_on && !pump_q) begin
         if (arr_prog_addr == `EEC_IDX_NVOPT)
            nvo <= arr_op[0] ? 8'hff : nvo & arr_prog_data;
         else
            for (int i = 0; i < 512; i++) begin
               if (arr_op == 2'b00 && i == a)
                  mem[i] <= mem[i] & arr_prog_data;
               else if (arr_op == 2'b01 && i == a || arr_op == 2'b11 ||
                        arr_op == 2'b10 && i[8:7] == a[8:7])
                  mem[i] <= 8'hff;
            end
      end
   end
endmodule

// ==== test/eeprom_program_erase_control_test.sv ====
`timescale 1ns/1ps
`include "eec_consts.svh"

module eeprom_program_erase_control_test;
   localparam logic [15:0] CR = `EEC_IDX_CTRL;
   localparam logic [15:0] AC = `EEC_IDX_ACR;
   localparam logic [15:0] DH = `EEC_IDX_DIVH;
   localparam logic [15:0] DL = `EEC_IDX_DIVL;
   localparam logic [15:0] NV = `EEC_IDX_NVOPT;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic hready;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [7:0] nv_option, nv_div_hi, nv_div_lo, arr_rdata, arr_prog_data, q;
   logic [15:0] arr_rd_addr, arr_prog_addr;
   logic [1:0] arr_op;
   logic arr_rd_en, arr_pump_on, arr_power_down, hresp;
   int num_errors = 0;
   int total_checks = 0;

   always #5 hclk = ~hclk;

   eec_program_erase_ctl #(.PGM_TICKS(16'h0003), .BYTE_ERASE_TICKS(16'h0003),
      .BLOCK_ERASE_TICKS(16'h0003), .BULK_ERASE_TICKS(16'h0003)) dut (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .nv_option(nv_option), .nv_div_hi(nv_div_hi), .nv_div_lo(nv_div_lo),
      .arr_rdata(arr_rdata), .arr_rd_en(arr_rd_en),
      .arr_rd_addr(arr_rd_addr), .arr_prog_addr(arr_prog_addr),
      .arr_prog_data(arr_prog_data), .arr_op(arr_op),
      .arr_pump_on(arr_pump_on), .arr_power_down(arr_power_down));

   eec_array_model far (
      .hclk(hclk), .arr_rd_en(arr_rd_en), .arr_rd_addr(arr_rd_addr),
      .arr_prog_addr(arr_prog_addr), .arr_prog_data(arr_prog_data),
      .arr_op(arr_op), .arr_pump_on(arr_pump_on),
      .arr_power_down(arr_power_down), .arr_rdata(arr_rdata),
      .nv_option(nv_option), .nv_div_hi(nv_div_hi), .nv_div_lo(nv_div_lo));

   task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // address phase held until hready, then data phase until hready
   task bus(input logic w, input logic [15:0] i, input logic [7:0] d);
      hsel <= 1'b1;
      hwrite <= w;
      haddr <= {14'h0, i, 2'b00};
      htrans <= 2'b10;
      @(posedge hclk iff hready === 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      @(posedge hclk iff hready === 1'b1);
      // hsel stays up between transfers, idle htrans marks the gap
      q = hrdata[7:0];
   endtask

   task wr(input logic [15:0] i, input logic [7:0] d);
      bus(1'b1, i, d);
   endtask

   task rd(input logic [15:0] i, input logic [7:0] e);
      bus(1'b0, i, 8'h00);
      chk($sformatf("read %h", i), {hrdata[15:9], hresp, q}, {8'h0, e});
   endtask

   task do_reset();
      hresetn <= 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask

   // one auto-terminated operation; e says whether it is permitted
   task op_run(input logic [1:0] op, input logic [15:0] i, input logic [7:0] d,
               input logic e);
      int n;
      n = 0;
      wr(CR, {3'b000, op, 3'b110});
      wr(i, d);
      wr(CR, {3'b000, op, 3'b111});
      chk("prog_addr", arr_prog_addr, i);
      chk("prog_data", {8'h0, arr_prog_data}, {8'h0, d});
      @(negedge hclk);
      chk("pump", 16'(arr_pump_on), 16'(e));
      while (arr_pump_on === 1'b1 && n < 300) begin
         @(negedge hclk);
         n++;
      end
      chk("auto_end", 16'(n < 300), 16'h1);
      @(posedge hclk);
      rd(CR, {3'b000, op, 2'b11, ~e});
      wr(CR, {3'b000, op, 3'b110});
      wr(CR, 8'h00);
   endtask

   task t_reset();
      rd(CR, `EEC_CTRL_RST);
      rd(AC, `EEC_NV_FACTORY);
      rd(DH, 8'h80);
      rd(DL, 8'h02);
      wr(AC, 8'h00);
      rd(AC, `EEC_NV_FACTORY);
      rd(16'h0004, 8'h00);
      $display("test reset done");
   endtask

   task t_ctrl();
      wr(CR, 8'h80);
      rd(CR, 8'h80);
      wr(CR, 8'h20);
      rd(CR, 8'h20);
      chk("power_down", 16'(arr_power_down), 16'h1);
      wr(CR, 8'h01);
      @(negedge hclk);
      chk("pump_nolatch", 16'(arr_pump_on), 16'h0);
      chk("power_up", 16'(arr_power_down), 16'h0);
      @(posedge hclk);
      wr(CR, 8'h00);
      $display("test control done");
   endtask

   task t_div();
      wr(DL, 8'h03);
      rd(DL, 8'h03);
      wr(CR, 8'h04);
      wr(DL, 8'h07);
      rd(DL, 8'h03);
      wr(CR, 8'h00);
      $display("test divisor done");
   endtask

   task t_latch();
      wr(CR, 8'h04);
      wr(`EEC_ARR_HI, 8'h22);
      wr(`EEC_ARR_LO, 8'h11);
      wr(16'h0a00, 8'h33);
      rd(`EEC_ARR_HI, 8'h11);
      wr(CR, 8'h05);
      chk("last_addr", arr_prog_addr, `EEC_ARR_HI);
      chk("last_data", {8'h0, arr_prog_data}, 16'h0011);
      @(negedge hclk);
      chk("pump_on", 16'(arr_pump_on), 16'h1);
      @(posedge hclk);
      wr(CR, 8'h01);
      rd(CR, 8'h05);
      wr(CR, 8'h00);
      rd(CR, 8'h04);
      chk("pump_off", 16'(arr_pump_on), 16'h0);
      wr(CR, 8'h00);
      rd(`EEC_ARR_HI, 8'h11);
      $display("test latch done");
   endtask

   task t_modes();
      op_run(2'b10, 16'h0900, 8'h00, 1'b1);
      op_run(2'b11, 16'h0980, 8'h00, 1'b1);
      rd(`EEC_ARR_HI, 8'hff);
      op_run(2'b00, 16'h08f5, 8'h00, 1'b1);
      rd(16'h08f5, 8'h00);
      op_run(2'b01, NV, 8'h00, 1'b1);
      op_run(2'b00, NV, 8'he1, 1'b1);
      $display("test modes done");
   endtask

   // option now secured with quarter zero guarded, takes effect at reset
   task t_secure();
      do_reset();
      rd(AC, 8'he1);
      op_run(2'b00, `EEC_ARR_LO, 8'h00, 1'b0);
      rd(`EEC_ARR_LO, 8'hff);
      op_run(2'b00, 16'h0880, 8'h00, 1'b1);
      rd(16'h0880, 8'h00);
      op_run(2'b00, 16'h08f5, 8'h00, 1'b0);
      op_run(2'b10, 16'h0900, 8'h00, 1'b0);
      op_run(2'b01, 16'h0900, 8'h00, 1'b1);
      op_run(2'b01, NV, 8'h00, 1'b0);
      $display("test secure done");
   endtask

   task t_lock();
      rd(DL, 8'h02);
      wr(DH, 8'h00);
      rd(DH, 8'h00);
      wr(DH, 8'h80);
      rd(DH, 8'h00);
      wr(DL, 8'h05);
      rd(DL, 8'h02);
      $display("test lock done");
   endtask

   task tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      do_reset();
      t_reset();
      t_ctrl();
      t_div();
      t_latch();
      t_modes();
      t_secure();
      t_lock();
      tally_and_finish();
   end

   // whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge hclk);
      num_errors++;
      tally_and_finish();
   end
endmodule
